//--- src/hbdc_pkg.sv
// hbdc_pkg: register map, field layout, reset values and carrier types of the hardware break block
package hbdc_pkg;
    localparam int unsigned AW      = 24;
    localparam int unsigned DW      = 16;
    localparam int unsigned NCH     = 2;
    // register byte offsets
    localparam logic [7:0] OFF_CTRL  = 8'h00;
    localparam logic [7:0] OFF_STAT  = 8'h04;
    localparam logic [7:0] OFF_MASK  = 8'h08;
    localparam logic [7:0] OFF_STATE = 8'h0c;
    localparam logic [7:0] OFF_CH0   = 8'h10;
    localparam logic [7:0] OFF_CHSTP = 8'h10;
    localparam logic [7:0] OFF_CADR  = 8'h00;
    localparam logic [7:0] OFF_CDAT  = 8'h04;
    localparam logic [7:0] OFF_CCFG  = 8'h08;
    localparam logic [7:0] OFF_SAVED = 8'h30;
    localparam logic [7:0] OFF_MEM   = 8'h34;
    // control register fields
    localparam int unsigned CT_GOTO   = 0;
    localparam int unsigned CT_STEP   = 1;
    localparam int unsigned CT_STOVR  = 2;
    localparam int unsigned CT_RST    = 3;
    localparam int unsigned CT_START  = 4;
    localparam int unsigned CT_RESUME = 5;
    localparam int unsigned CT_W      = 4;
    // status / mask fields
    localparam int unsigned ST_BRK0  = 0;
    localparam int unsigned ST_BRK1  = 1;
    localparam int unsigned ST_RSTMN = 2;
    localparam int unsigned ST_W     = 3;
    // channel config fields
    localparam int unsigned CF_AEN  = 0;
    localparam int unsigned CF_DEN  = 1;
    localparam int unsigned CF_REN  = 2;
    localparam int unsigned CF_RWR  = 3;
    localparam int unsigned CF_WORD = 4;
    localparam int unsigned CF_W    = 5;
    // emulator start values, system control reset value and AHB transfer code
    localparam logic [31:0] INIT_SP  = 32'h00ffc000;
    localparam logic [7:0]  INIT_EXR = 8'h07;
    localparam logic        INIT_CCRI = 1'b1;
    localparam logic [7:0]  SYSCR_RST = 8'h00;
    localparam logic [1:0]  HTRANS_NONSEQ = 2'h2;

    typedef struct packed {
        logic [AW-1:0] addr;
        logic [DW-1:0] data;
        logic          valid;
        logic          write;
    } hbdc_bus_t;

    typedef struct packed {
        logic [AW-1:0] addr;
        logic [DW-1:0] data;
        logic          addr_en;
        logic          data_en;
        logic          dir_en;
        logic          dir_wr;
        logic          size_word;
    } hbdc_chcfg_t;

    typedef struct packed {
        logic [AW-1:0] pc;
        logic [31:0]   sp;
        logic [7:0]    extended_control_reg;
        logic          ccr_i;
        logic          load;
    } hbdc_init_t;
endpackage

//--- src/hbdc_chan.sv
// hbdc_chan: one hardware break channel comparing address, data and direction
`timescale 1ns/1ps
`default_nettype none
module hbdc_chan
    import hbdc_pkg::*;
(
    input  wire hbdc_pkg::hbdc_chcfg_t cfg,
    input  wire hbdc_pkg::hbdc_bus_t   bus,
    output logic                       hit
);
    logic a_ok;
    logic d_ok;
    logic r_ok;

    // each disabled condition counts as matching
    always_comb begin
        a_ok = !cfg.addr_en || (bus.addr == cfg.addr);
        if (!cfg.data_en) begin
            d_ok = 1'b1;
        end else if (cfg.size_word) begin
            d_ok = (bus.data == cfg.data);
        end else begin
            d_ok = (bus.data[7:0] == cfg.data[7:0]);
        end
        r_ok = !cfg.dir_en || (bus.write == cfg.dir_wr);
        hit  = bus.valid && a_ok && d_ok && r_ok;
    end
endmodule
`default_nettype wire

//--- src/hbdc_top.sv
// hbdc_top: hardware break channels, debug control and AHB-Lite register slave
//
// Operation
// - Two independent break channels each hold their own address, data and direction conditions.
// - An enabled address condition matches when the processor address bus equals the programmed address.
// - An enabled data condition matches the data bus on the low byte or the whole word as selected.
// - An enabled direction condition restricts the break to read or to write cycles.
// - Run-to-location and every step mode make the channels ignored.
// - A cycle executing a software breakpoint instruction raises no channel break.
// - Step over disables both software breakpoints and the channels.
// - Emulator start loads the reset vector, stack pointer ffc000, extended control 07 and interrupt mask 1.
// - The system control value is saved at a break and written back at resume; debugger leaves it alone.
// - A debugger memory access while running pauses the processor until the access ends.
//
// The AHB-Lite interface to the registers and the address map were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module hbdc_top
    import hbdc_pkg::*;
#(
    parameter int unsigned CHANNELS = hbdc_pkg::NCH
)
(
    input  wire logic                  hclk,
    input  wire logic                  hresetn,
    input  wire logic                  hsel,
    input  wire logic [31:0]           haddr,
    input  wire logic [1:0]            htrans,
    input  wire logic                  hwrite,
    input  wire logic [2:0]            hsize,
    input  wire logic [31:0]           hwdata,
    input  wire logic                  hready,
    output logic [31:0]                hrdata,
    output logic                       hreadyout,
    output logic                       hresp,
    input  wire hbdc_pkg::hbdc_bus_t   cpu_bus,
    input  wire logic                  cpu_swbrk_exec,
    input  wire logic [AW-1:0]         reset_vector,
    input  wire logic [7:0]            syscr_in,
    input  wire logic                  cpu_reset_line_n,
    input  wire logic                  mem_done,
    output logic                       cpu_halt,
    output logic                       cpu_pause,
    output logic                       sw_brk_en,
    output logic                       emu_reset_out_n,
    output logic                       syscr_wr,
    output logic [7:0]                 syscr_out,
    output hbdc_pkg::hbdc_init_t       init_out,
    output logic                       irq
);
    import hbdc_pkg::*;

    // unpack a channel config word into the carrier type
    function automatic hbdc_chcfg_t mk_cfg(input logic [AW-1:0] a, input logic [DW-1:0] d,
                                           input logic [CF_W-1:0] c);
        hbdc_chcfg_t r;
        r.addr      = a;
        r.data      = d;
        r.addr_en   = c[CF_AEN];
        r.data_en   = c[CF_DEN];
        r.dir_en    = c[CF_REN];
        r.dir_wr    = c[CF_RWR];
        r.size_word = c[CF_WORD];
        return r;
    endfunction

    // byte offset of a register within channel n
    function automatic logic [7:0] ch_off(input int unsigned n, input logic [7:0] sub);
        return 8'(OFF_CH0 + 8'(n) * OFF_CHSTP + sub);
    endfunction

    // bus-phase state
    logic                 wr_pend_r,  wr_pend_nxt;
    logic [7:0]           wr_addr_r,  wr_addr_nxt;
    logic [31:0]          rdata_r,    rdata_nxt;
    logic                 ready_r,    ready_nxt;
    // register file
    logic [CT_W-1:0]      ctrl_r,     ctrl_nxt;
    logic [ST_W-1:0]      stat_r,     stat_nxt;
    logic [ST_W-1:0]      mask_r,     mask_nxt;
    logic [AW-1:0]        ch_addr_r [CHANNELS];
    logic [AW-1:0]        ch_addr_nxt [CHANNELS];
    logic [DW-1:0]        ch_data_r [CHANNELS];
    logic [DW-1:0]        ch_data_nxt [CHANNELS];
    logic [CF_W-1:0]      ch_cfg_r [CHANNELS];
    logic [CF_W-1:0]      ch_cfg_nxt [CHANNELS];
    // debug control state
    logic                 halt_r,     halt_nxt;
    logic                 pause_r,    pause_nxt;
    logic                 swen_r,     swen_nxt;
    logic                 rstn_r,     rstn_nxt;
    logic [7:0]           saved_r,    saved_nxt;
    logic                 restore_r,  restore_nxt;
    logic                 mon_prev_r, mon_prev_nxt;
    logic                 irq_r,      irq_nxt;
    hbdc_init_t           init_r,     init_nxt;

    logic [CHANNELS-1:0]  hit;
    logic                 brk_gate;
    logic                 brk_any;
    logic                 wr_now;
    logic                 start_req;
    logic                 resume_req;
    logic                 mem_req;
    logic                 addr_ph;

    // break channels
    for (genvar g = 0; g < CHANNELS; g++) begin : g_ch
        hbdc_chan u_chan (
            .cfg (mk_cfg(ch_addr_r[g], ch_data_r[g], ch_cfg_r[g])),
            .bus (cpu_bus),
            .hit (hit[g])
        );
    end

    // break qualification and write strobes
    // halted or paused cycles are not user execution, so no channel may fire then
    always_comb begin
        brk_gate = !ctrl_r[CT_GOTO] && !ctrl_r[CT_STEP]
                   && !ctrl_r[CT_STOVR]
                   && !cpu_swbrk_exec
                   && !halt_r && !pause_r;
        brk_any    = brk_gate && (|hit);
        wr_now     = wr_pend_r;
        start_req  = wr_now && (wr_addr_r == OFF_CTRL) && hwdata[CT_START];
        resume_req = wr_now && (wr_addr_r == OFF_CTRL) && hwdata[CT_RESUME];
        mem_req    = wr_now && (wr_addr_r == OFF_MEM) && hwdata[0];
        addr_ph    = hsel && hready && (htrans == HTRANS_NONSEQ);
    end

    // AHB-Lite address phase capture and read data
    // ready comes from a flip-flop, so it rises one edge after reset release
    always_comb begin
        wr_pend_nxt = addr_ph && hwrite;
        wr_addr_nxt = haddr[7:0];
        rdata_nxt   = 32'h0000_0000;
        ready_nxt   = 1'b1;                                            // no wait states
        if (addr_ph && !hwrite) begin
            if (haddr[7:0] == OFF_CTRL) begin
                rdata_nxt = 32'(ctrl_r);
            end else if (haddr[7:0] == OFF_STAT) begin
                rdata_nxt = 32'(stat_r);
            end else if (haddr[7:0] == OFF_MASK) begin
                rdata_nxt = 32'(mask_r);
            end else if (haddr[7:0] == OFF_STATE) begin
                rdata_nxt = {28'h0000000, cpu_reset_line_n, pause_r, swen_r, halt_r};
            end else if (haddr[7:0] == OFF_SAVED) begin
                rdata_nxt = 32'(saved_r);
            end else if (haddr[7:0] == OFF_MEM) begin
                rdata_nxt = 32'(pause_r);
            end else begin
                // channel registers sit at a fixed stride above the global ones
                for (int unsigned n = 0; n < CHANNELS; n++) begin
                    if (haddr[7:0] == ch_off(n, OFF_CADR)) begin
                        rdata_nxt = 32'(ch_addr_r[n]);
                    end else if (haddr[7:0] == ch_off(n, OFF_CDAT)) begin
                        rdata_nxt = 32'(ch_data_r[n]);
                    end else if (haddr[7:0] == ch_off(n, OFF_CCFG)) begin
                        rdata_nxt = 32'(ch_cfg_r[n]);
                    end
                end
            end
        end
    end

    // register writes; hardware set beats write-one-to-clear
    always_comb begin
        ctrl_nxt    = ctrl_r;
        mask_nxt    = mask_r;
        stat_nxt    = stat_r;
        ch_addr_nxt = ch_addr_r;
        ch_data_nxt = ch_data_r;
        ch_cfg_nxt  = ch_cfg_r;
        if (wr_now) begin
            if (wr_addr_r == OFF_CTRL) begin
                ctrl_nxt = hwdata[CT_W-1:0];
            end else if (wr_addr_r == OFF_STAT) begin
                stat_nxt = stat_r & ~hwdata[ST_W-1:0];
            end else if (wr_addr_r == OFF_MASK) begin
                mask_nxt = hwdata[ST_W-1:0];
            end else begin
                for (int unsigned n = 0; n < CHANNELS; n++) begin
                    if (wr_addr_r == ch_off(n, OFF_CADR)) begin
                        ch_addr_nxt[n] = hwdata[AW-1:0];
                    end else if (wr_addr_r == ch_off(n, OFF_CDAT)) begin
                        ch_data_nxt[n] = hwdata[DW-1:0];
                    end else if (wr_addr_r == ch_off(n, OFF_CCFG)) begin
                        ch_cfg_nxt[n] = hwdata[CF_W-1:0];
                    end
                end
            end
        end
        // a break and a write-one-to-clear in one cycle leave the bit set
        if (brk_gate && hit[0]) begin
            stat_nxt[ST_BRK0] = 1'b1;
        end
        if (brk_gate && hit[CHANNELS-1]) begin
            stat_nxt[ST_BRK1] = 1'b1;
        end
        if (mon_prev_r && !cpu_reset_line_n) begin
            stat_nxt[ST_RSTMN] = 1'b1;                                 // reset seen on the monitor line
        end
    end

    // halt, save/restore, pause, reset drive and start values
    always_comb begin
        halt_nxt     = halt_r;
        saved_nxt    = saved_r;
        restore_nxt  = 1'b0;
        pause_nxt    = pause_r;
        swen_nxt     = !ctrl_nxt[CT_STOVR];
        rstn_nxt     = !ctrl_nxt[CT_RST];
        mon_prev_nxt = cpu_reset_line_n;
        init_nxt     = init_r;
        init_nxt.load = 1'b0;
        // the live value is captured at the break and replayed as a one-cycle write at resume
        if (brk_any) begin
            halt_nxt  = 1'b1;
            saved_nxt = syscr_in;
        end else if (resume_req && halt_r) begin
            halt_nxt    = 1'b0;
            restore_nxt = 1'b1;
        end
        // a pause only starts while running; a halted processor already leaves the bus free
        if (mem_req && !halt_r) begin
            pause_nxt = 1'b1;
        end else if (mem_done) begin
            pause_nxt = 1'b0;
        end
        // start values stand with a one-cycle load pulse for the processor to take
        if (start_req) begin
            init_nxt.pc    = reset_vector;
            init_nxt.sp    = INIT_SP;
            init_nxt.extended_control_reg   = INIT_EXR;
            init_nxt.ccr_i = INIT_CCRI;
            init_nxt.load  = 1'b1;
        end
        irq_nxt = |(stat_nxt & mask_nxt);
    end

    // state registers
    // the monitor edge detector resets to the line's idle high level, so no false fall follows reset
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_r  <= 1'b0;
            wr_addr_r  <= 8'h00;
            rdata_r    <= 32'h0000_0000;
            ready_r    <= 1'b0;
            ctrl_r     <= '0;
            stat_r     <= '0;
            mask_r     <= '0;
            ch_addr_r  <= '{default: '0};
            ch_data_r  <= '{default: '0};
            ch_cfg_r   <= '{default: '0};
            halt_r     <= 1'b0;
            pause_r    <= 1'b0;
            swen_r     <= 1'b1;
            rstn_r     <= 1'b1;
            saved_r    <= SYSCR_RST;
            restore_r  <= 1'b0;
            mon_prev_r <= 1'b1;
            irq_r      <= 1'b0;
            init_r     <= '0;
        end else begin
            wr_pend_r  <= wr_pend_nxt;
            wr_addr_r  <= wr_addr_nxt;
            rdata_r    <= rdata_nxt;
            ready_r    <= ready_nxt;
            ctrl_r     <= ctrl_nxt;
            stat_r     <= stat_nxt;
            mask_r     <= mask_nxt;
            ch_addr_r  <= ch_addr_nxt;
            ch_data_r  <= ch_data_nxt;
            ch_cfg_r   <= ch_cfg_nxt;
            halt_r     <= halt_nxt;
            pause_r    <= pause_nxt;
            swen_r     <= swen_nxt;
            rstn_r     <= rstn_nxt;
            saved_r    <= saved_nxt;
            restore_r  <= restore_nxt;
            mon_prev_r <= mon_prev_nxt;
            irq_r      <= irq_nxt;
            init_r     <= init_nxt;
        end
    end

    // outputs straight from flip-flops; zero-wait slave, always OKAY
    // the response is a constant, as no transfer is ever refused
    assign hrdata          = rdata_r;
    assign hreadyout       = ready_r;
    assign hresp           = 1'b0;
    assign cpu_halt        = halt_r;
    assign cpu_pause       = pause_r;
    assign sw_brk_en       = swen_r;
    assign emu_reset_out_n = rstn_r;
    assign syscr_wr        = restore_r;
    assign syscr_out       = saved_r;
    assign init_out        = init_r;
    assign irq             = irq_r;
endmodule
`default_nettype wire

//--- test/hbdc_top_sva.sv
// hbdc_top_sva: port assertions of the hardware break block
`timescale 1ns/1ps
`default_nettype none
module hbdc_top_sva
    import hbdc_pkg::*;
(
    input wire logic                 hclk,
    input wire logic                 hresetn,
    input wire hbdc_pkg::hbdc_bus_t  cpu_bus,
    input wire logic                 cpu_swbrk_exec,
    input wire logic [AW-1:0]        reset_vector,
    input wire logic [7:0]           syscr_in,
    input wire logic                 mem_done,
    input wire logic                 cpu_halt,
    input wire logic                 cpu_pause,
    input wire logic                 sw_brk_en,
    input wire logic                 syscr_wr,
    input wire logic [7:0]           syscr_out,
    input wire hbdc_pkg::hbdc_init_t init_out
);
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    // no break while step over holds the channels off
    property p_stovr; !sw_brk_en && !cpu_halt |=> !cpu_halt; endproperty
    a_stovr: assert property (p_stovr) else $error("break taken in step over");
    // a software breakpoint cycle raises no break
    property p_swbrk; cpu_swbrk_exec && !cpu_halt |=> !cpu_halt; endproperty
    a_swbrk: assert property (p_swbrk) else $error("break on software breakpoint");
    // no break during a debugger memory access
    property p_pgate; cpu_pause && !cpu_halt |=> !cpu_halt; endproperty
    a_pgate: assert property (p_pgate) else $error("break while paused");
    // pause holds until the access completes
    property p_phold; cpu_pause && !mem_done |=> cpu_pause; endproperty
    a_phold: assert property (p_phold) else $error("pause dropped early");
    // a break only comes from a real bus cycle
    property p_cause; $rose(cpu_halt) |-> $past(cpu_bus.valid); endproperty
    a_cause: assert property (p_cause) else $error("break without bus cycle");
    // system control value captured at the break
    property p_save; $rose(cpu_halt) |-> syscr_out == $past(syscr_in); endproperty
    a_save: assert property (p_save) else $error("system control not saved");
    // leaving the break writes the value back once
    property p_rest; $fell(cpu_halt) |-> syscr_wr ##1 !syscr_wr; endproperty
    a_rest: assert property (p_rest) else $error("system control not restored");
    // start values of the processor registers
    property p_init; init_out.load |-> init_out.sp == INIT_SP && init_out.extended_control_reg == INIT_EXR
        && init_out.ccr_i && init_out.pc == $past(reset_vector) ##1 !init_out.load; endproperty
    a_init: assert property (p_init) else $error("bad start values");
endmodule
bind hbdc_top hbdc_top_sva i_sva (.*);
`default_nettype wire

//--- test/hbdc_cpu_model.sv
// hbdc_cpu_model: user system around the processor reset and memory access
`timescale 1ns/1ps
`default_nettype none
module hbdc_cpu_model (
    input wire logic        hclk,
    input wire logic        hresetn,
    input wire logic        emu_reset_out_n,
    input wire logic        user_rst_n,
    input wire logic        cpu_pause,
    input wire logic [3:0]  dly,
    output logic            cpu_reset_line_n,
    output logic            mem_done
);
    logic [3:0] cnt_r;
    // monitor line pulled up, low when either reset source pulls
    assign cpu_reset_line_n = emu_reset_out_n & user_rst_n;
    // access completes dly cycles into the pause
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) cnt_r <= 4'h0;
        else cnt_r <= cpu_pause ? cnt_r + 4'h1 : 4'h0;
    end
    assign mem_done = cpu_pause && cnt_r == dly;
endmodule
`default_nettype wire

//--- test/hbdc_top_bench.sv
// hbdc_top_bench: self-checking bench of the hardware break block
`timescale 1ns/1ps
`default_nettype none
module hbdc_top_bench;
    import hbdc_pkg::*;
    logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, cpu_swbrk_exec, cpu_reset_line_n, mem_done;
    logic cpu_halt, cpu_pause, sw_brk_en, emu_reset_out_n, syscr_wr, irq, user_rst_n;
    logic [31:0] haddr, hwdata, hrdata, r;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [AW-1:0] reset_vector;
    logic [7:0] syscr_in;
    logic [7:0] syscr_out;
    logic [3:0] dly;
    wire logic hready = hreadyout;
    hbdc_bus_t cpu_bus;
    hbdc_init_t init_out;
    int errors, total_checks, nwr, i, c, g, a, d, w, mk, sy, ex, n0;
    int ca[2], cd[2], cf[2];
    hbdc_top i_hbdc_top (.*);
    hbdc_cpu_model i_hbdc_cpu_model (.hclk(hclk), .hresetn(hresetn), .emu_reset_out_n(emu_reset_out_n),
        .user_rst_n(user_rst_n), .cpu_pause(cpu_pause), .dly(dly), .cpu_reset_line_n(cpu_reset_line_n),
        .mem_done(mem_done));
    initial begin
        hclk = 0;
        forever #50 hclk = ~hclk;
    end
    // count write-back pulses
    always @(posedge hclk) if (syscr_wr === 1'b1) nwr++;
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            errors++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic complete_run;
        $display("checks %0d mismatches %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    // one single AHB-Lite word transfer
    task automatic ahb(input logic wr, input logic [7:0] ad, input logic [31:0] wd);
        @(posedge hclk);
        {hsel, htrans, haddr, hwrite} <= {1'b1, HTRANS_NONSEQ, 24'h0, ad, wr};
        do @(posedge hclk); while (hreadyout !== 1'b1);
        {hsel, htrans, hwdata} <= {3'h0, wd};
        do @(posedge hclk); while (hreadyout !== 1'b1);
        r = hrdata;
    endtask
    // one processor bus cycle
    task automatic cyc(input int ad, input int dd, input int wr, input int sw);
        @(posedge hclk);
        cpu_bus <= {ad[23:0], dd[15:0], 1'b1, wr[0]};
        cpu_swbrk_exec <= sw[0];
        @(posedge hclk);
        cpu_bus.valid <= 1'b0;
        cpu_swbrk_exec <= 1'b0;
        @(negedge hclk);
    endtask
    function automatic int hit(int k, int ad, int dd, int wr);
        return (!cf[k][0] || ad == ca[k]) && (!cf[k][1] || (cf[k][4] ? dd == cd[k] : dd[7:0] == cd[k][7:0]))
            && (!cf[k][2] || wr == cf[k][3]);
    endfunction
    task automatic resume;
        n0 = nwr;
        ahb(1, OFF_CTRL, 32'h20);
        repeat (2) @(negedge hclk);
        chk(cpu_halt, 0);
        chk(nwr - n0, 1);
    endtask
    initial begin
        repeat (20000) @(posedge hclk);
        errors++;
        complete_run;
    end
    initial begin
        {hsel, hwrite, cpu_swbrk_exec, haddr, hwdata, htrans, cpu_bus} = '0;
        {hresetn, user_rst_n, hsize, syscr_in} = {2'b01, 3'h2, 8'h00};
        void'($urandom(32'hdbdc));
        reset_vector = AW'($urandom);
        dly = 4'h6;
        repeat (4) @(posedge hclk);
        hresetn <= 1'b1;
        ahb(0, OFF_STATE, 0);
        chk(r, 32'ha);
        ahb(0, 8'h3c, 0);
        chk(r, 0);
        chk(hresp, 0);
        ahb(1, OFF_CTRL, 32'h10);
        for (i = 0; i < 8 && init_out.load !== 1'b1; i++) @(negedge hclk);
        chk({init_out.pc, init_out.extended_control_reg}, {reset_vector, 8'h07});
        chk(init_out.sp, 32'h00ffc000);
        $display("test reset and start done");
        for (i = 0; i < 16; i++) begin
            for (c = 0; c < 2; c++) begin
                {ca[c], cd[c], cf[c]} = {$urandom & 24'hffffff, $urandom & 16'hffff, $urandom & 5'h1f};
                ahb(1, OFF_CH0 + 8'(c * 16), ca[c]);
                ahb(1, OFF_CH0 + 8'(c * 16 + 4), cd[c]);
                ahb(1, OFF_CH0 + 8'(c * 16 + 8), cf[c]);
            end
            mk = $urandom & 3;
            ahb(1, OFF_MASK, mk);
            c = $urandom & 1;
            a = ($urandom & 1) ? ca[c] : $urandom & 24'hffffff;
            d = ($urandom & 1) ? cd[c] : $urandom & 16'hffff;
            w = $urandom & 1;
            sy = $urandom & 8'hff;
            syscr_in <= sy[7:0];
            ex = hit(1, a, d, w) * 2 + hit(0, a, d, w);
            cyc(a, d, w, 0);
            chk(cpu_halt, ex != 0);
            ahb(0, OFF_STAT, 0);
            chk(r, ex);
            chk(irq, (ex & mk) != 0);
            if (ex != 0) begin
                chk(syscr_out, sy);
                ahb(0, OFF_SAVED, 0);
                chk(r, sy);
                syscr_in <= ~sy[7:0];
                resume;
                chk(syscr_out, sy);
            end
            ahb(1, OFF_STAT, 3);
            repeat (2) @(negedge hclk);
            chk(irq, 0);
        end
        $display("test channel matching done");
        for (c = 0; c < 2; c++) begin
            {ca[c], cf[c]} = {24'h123456, 1};
            ahb(1, OFF_CH0 + 8'(c * 16), ca[c]);
            ahb(1, OFF_CH0 + 8'(c * 16 + 8), cf[c]);
        end
        // goto, step, step over, software break, plain, paused
        for (g = 0; g < 6; g++) begin
            ahb(1, OFF_CTRL, g < 3 ? 1 << g : 0);
            if (g == 5) ahb(1, OFF_MEM, 1);
            cyc(24'h123456, 0, 0, g == 3);
            chk(cpu_halt, g == 4);
            if (g == 2) chk(sw_brk_en, 0);
            if (g == 5) begin
                chk(cpu_pause, 1);
                ahb(0, OFF_MEM, 0);
                chk(r, 1);
            end
            if (g == 4) resume;
            for (i = 0; i < 20 && cpu_pause !== 1'b0; i++) @(negedge hclk);
            chk(cpu_pause, 0);
            ahb(1, OFF_STAT, 3);
        end
        $display("test break gating done");
        ahb(1, OFF_MASK, 4);
        ahb(1, OFF_CTRL, 8);
        repeat (3) @(negedge hclk);
        chk({emu_reset_out_n, cpu_reset_line_n, irq}, 3'b001);
        ahb(0, OFF_STAT, 0);
        chk(r, 4);
        ahb(1, OFF_CTRL, 0);
        ahb(1, OFF_STAT, 4);
        repeat (2) @(negedge hclk);
        chk({cpu_reset_line_n, irq}, 2'b10);
        $display("test reset drive done");
        complete_run;
    end
endmodule
`default_nettype wire
